// File: logic/hrm_result_mapper.sv
/*
 * result mapper of a dual-pixel three-axis field sensor: sequencer
 * register, measurement rate, result slot routing, cordic and
 * angle linearization, register read port.
 * assumes the front end, the host port logic and the table loader
 * run on ref_clk_in; field words arrive with a one-cycle strobe.
 */
`default_nettype none
`include "hrm_cfg.svh"

module hrm_result_mapper #(
    parameter int FAST_PERIOD_CYC = `HRM_FAST_PERIOD_US * `HRM_CLK_MHZ,
    parameter int SLOW_PERIOD_CYC = `HRM_SLOW_PERIOD_US * `HRM_CLK_MHZ
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic sample_valid_in,
    input wire logic [15:0] temperature_in,
    input wire logic [15:0] pixel_a_x_field_in,
    input wire logic [15:0] pixel_a_y_field_in,
    input wire logic [15:0] pixel_a_z_field_in,
    input wire logic [15:0] pixel_b_x_field_in,
    input wire logic [15:0] pixel_b_y_field_in,
    input wire logic [15:0] pixel_b_z_field_in,
    input wire logic lin_wr_in,
    input wire logic [4:0] lin_idx_in,
    input wire logic [16:0] lin_data_in,
    output logic meas_trigger_out,
    output logic [5:0] measure_mask_out,
    output logic ready_pin_hiz_out
);
    localparam int CW = 20; // cordic width, room for gain and sign
    localparam logic [16:0] FAST_RELOAD = 17'(FAST_PERIOD_CYC - 1);
    localparam logic [16:0] SLOW_RELOAD = 17'(SLOW_PERIOD_CYC - 1);

    // arctan(2^-i) in angle units of 180 deg / 32768
    function automatic logic [15:0] hrm_atan(input logic [3:0] i);
        unique case (i)
            4'h0: hrm_atan = 16'h2000;
            4'h1: hrm_atan = 16'h12E4;
            4'h2: hrm_atan = 16'h09FB;
            4'h3: hrm_atan = 16'h0511;
            4'h4: hrm_atan = 16'h028B;
            4'h5: hrm_atan = 16'h0146;
            4'h6: hrm_atan = 16'h00A3;
            4'h7: hrm_atan = 16'h0051;
            4'h8: hrm_atan = 16'h0029;
            4'h9: hrm_atan = 16'h0014;
            4'hA: hrm_atan = 16'h000A;
            4'hB: hrm_atan = 16'h0005;
            4'hC: hrm_atan = 16'h0003;
            4'hD: hrm_atan = 16'h0001;
            4'hE: hrm_atan = 16'h0001;
            4'hF: hrm_atan = 16'h0000;
        endcase
    endfunction

    // sequencer register and its decoded fields
    logic [15:0] seq_cfg_r; // host-written configuration
    wire cfg_wr = reg_wr_in && (reg_addr_in == `HRM_ADDR_SEQ_CFG);
    wire [1:0] map_sel = seq_cfg_r[`HRM_MAP_SEL_LSB +: 2];
    wire [1:0] extra_fld = seq_cfg_r[`HRM_EXTRA_LSB +: 2];
    wire gradient = seq_cfg_r[`HRM_GRADIENT_BIT];
    // extra slots need both fields; any other pairing keeps the table angle
    wire extra_on = (extra_fld == `HRM_EXTRA_ON) && (map_sel == `HRM_MAP_DUAL);

    // configuration write; every bit is stored, the host owns the pattern
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            seq_cfg_r <= `HRM_SEQ_RESET;
        end else if (cfg_wr) begin
            seq_cfg_r <= reg_wdata_in;
        end
    end

    // measurement rate: reloads on trigger and on a config write, a write with its own select's period
    logic [16:0] rate_cnt_r;
    logic [16:0] rate_cnt_nxt;
    wire [1:0] map_sel_new = cfg_wr ? reg_wdata_in[`HRM_MAP_SEL_LSB +: 2] : map_sel;
    wire [16:0] reload = (map_sel_new == `HRM_MAP_DUAL) ? SLOW_RELOAD : FAST_RELOAD;
    wire rate_hit = (rate_cnt_r == 17'h00000);
    assign rate_cnt_nxt = (rate_hit || cfg_wr) ? reload : rate_cnt_r - 17'h00001;

    // rate counter and front-end request outputs
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            rate_cnt_r <= 17'h00000;
            meas_trigger_out <= 1'b0;
            measure_mask_out <= 6'h07;
            ready_pin_hiz_out <= 1'b1;
        end else begin
            rate_cnt_r <= rate_cnt_nxt;
            meas_trigger_out <= rate_hit;
            // single probe asks pixel a only, all else asks both pixels
            measure_mask_out <= (map_sel == `HRM_MAP_SINGLE) ? 6'h07 : 6'h3F;
            ready_pin_hiz_out <= seq_cfg_r[`HRM_RDY_HIZ_BIT];
        end
    end

    // slot routing of the raw field words
    logic [15:0] map_fa, map_fb, map_sa, map_sb; // next raw slot contents
    always_comb begin
        unique case (map_sel)
            `HRM_MAP_SINGLE: {map_fa, map_fb, map_sa, map_sb} =
                {pixel_a_z_field_in, pixel_a_z_field_in, pixel_a_x_field_in, pixel_a_y_field_in};
            `HRM_MAP_DUAL: {map_fa, map_fb, map_sa, map_sb} =
                {pixel_b_y_field_in, pixel_a_y_field_in, pixel_b_x_field_in, pixel_a_x_field_in};
            `HRM_MAP_ONTOP: {map_fa, map_fb, map_sa, map_sb} =
                {pixel_a_z_field_in, pixel_b_z_field_in, pixel_a_x_field_in, pixel_b_x_field_in};
            `HRM_MAP_SIDE: {map_fa, map_fb, map_sa, map_sb} =
                {pixel_a_y_field_in, pixel_b_y_field_in, pixel_a_x_field_in, pixel_b_x_field_in};
        endcase
    end

    // cordic inputs: slot a pair, or b-minus-a difference in gradient
    wire signed [16:0] grad_first = 17'($signed(map_fb)) - 17'($signed(map_fa));
    wire signed [16:0] grad_second = 17'($signed(map_sb)) - 17'($signed(map_sa));
    wire signed [16:0] cin_first = gradient ? grad_first : 17'($signed(map_fa));
    wire signed [16:0] cin_second = gradient ? grad_second : 17'($signed(map_sa));

    // raw results, thermal word and the extra z words
    logic [15:0] thermal_r, first_a_r, first_b_r, second_a_r, second_b_r;
    logic [15:0] extra_b_z_r, extra_a_z_r;
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            thermal_r <= 16'h0000;
            first_a_r <= 16'h0000;
            first_b_r <= 16'h0000;
            second_a_r <= 16'h0000;
            second_b_r <= 16'h0000;
            extra_b_z_r <= 16'h0000;
            extra_a_z_r <= 16'h0000;
        end else if (sample_valid_in) begin
            thermal_r <= temperature_in;
            first_a_r <= map_fa;
            first_b_r <= map_fb;
            second_a_r <= map_sa;
            second_b_r <= map_sb;
            extra_b_z_r <= pixel_b_z_field_in;
            extra_a_z_r <= pixel_a_z_field_in;
        end
    end

    // iterative vectoring cordic; a sample that lands mid-run is not re-run
    hrm_pkg::hrm_cordic_e cst_r;
    logic [3:0] step_r;
    logic signed [CW-1:0] cx_r, cy_r;
    logic [15:0] cz_r; // angle accumulator, wraps at +-180 deg
    logic cordic_done_r;
    wire cordic_start = sample_valid_in && (cst_r == hrm_pkg::HRM_IDLE);
    wire signed [CW-1:0] ld_x = CW'(cin_second);
    wire signed [CW-1:0] ld_y = CW'(cin_first);
    wire signed [CW-1:0] sh_x = cx_r >>> step_r;
    wire signed [CW-1:0] sh_y = cy_r >>> step_r;
    wire rot_pos = !cy_r[CW-1];

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cst_r <= hrm_pkg::HRM_IDLE;
            step_r <= 4'h0;
            cx_r <= '0;
            cy_r <= '0;
            cz_r <= 16'h0000;
            cordic_done_r <= 1'b0;
        end else begin
            cordic_done_r <= 1'b0;
            unique case (cst_r)
                hrm_pkg::HRM_IDLE: begin
                    if (cordic_start) begin
                        // left half plane: turn by 180 deg first
                        cx_r <= ld_x[CW-1] ? -ld_x : ld_x;
                        cy_r <= ld_x[CW-1] ? -ld_y : ld_y;
                        cz_r <= ld_x[CW-1] ? 16'h8000 : 16'h0000;
                        step_r <= 4'h0;
                        cst_r <= hrm_pkg::HRM_ITER;
                    end
                end
                hrm_pkg::HRM_ITER: begin
                    cx_r <= rot_pos ? cx_r + sh_y : cx_r - sh_y;
                    cy_r <= rot_pos ? cy_r - sh_x : cy_r + sh_x;
                    cz_r <= rot_pos ? cz_r + hrm_atan(step_r) : cz_r - hrm_atan(step_r);
                    step_r <= step_r + 4'h1;
                    if (step_r == 4'(`HRM_CORDIC_STEPS - 1)) begin
                        cst_r <= hrm_pkg::HRM_IDLE;
                        cordic_done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // cordic gain is 1.6468, so half the final x is 0.8234 times the radius
    wire signed [CW-1:0] half_x = cx_r >>> 1;
    wire [15:0] mag_sat = (half_x > CW'(20'h0FFFF)) ? 16'hFFFF : half_x[15:0];

    // linearization table: 17 breakpoints, identity after reset
    logic signed [16:0] lin_tab_r [0:16];
    wire [15:0] ang_ofs = {~cz_r[15], cz_r[14:0]}; // angle shifted to unsigned
    wire [3:0] lin_seg = ang_ofs[15:12];
    wire [11:0] lin_frac = ang_ofs[11:0];
    wire signed [17:0] lin_delta = 18'(lin_tab_r[lin_seg + 5'h01]) - 18'(lin_tab_r[lin_seg]);
    wire signed [30:0] lin_prod = 31'(lin_delta) * $signed({19'h00000, lin_frac});
    wire signed [18:0] lin_sum = 19'(lin_tab_r[lin_seg]) + 19'(lin_prod >>> 12);
    // clip the table output to the signed 16-bit range
    wire [15:0] lin_sat = (lin_sum > 19'sh07FFF) ? 16'h7FFF :
                          (lin_sum < -19'sh08000) ? 16'h8000 : lin_sum[15:0];

    // table load port stands for the non-volatile table loader
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 17; i++) begin
                lin_tab_r[i] <= 17'(i * 4096 - 32768);
            end
        end else if (lin_wr_in && (lin_idx_in <= 5'h10)) begin
            lin_tab_r[lin_idx_in] <= lin_data_in;
        end
    end

    // processed results, committed together once the cordic finishes
    logic [15:0] strength_r, direction_r, lin_angle_r;
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            strength_r <= 16'h0000;
            direction_r <= 16'h0000;
            lin_angle_r <= 16'h0000;
        end else if (cordic_done_r) begin
            strength_r <= mag_sat;
            direction_r <= cz_r;
            lin_angle_r <= lin_sat;
        end
    end

    // read decode; unmapped offsets read as zero
    wire [15:0] slot_lin = extra_on ? extra_b_z_r : lin_angle_r;
    wire [15:0] slot_extra = extra_on ? extra_a_z_r : 16'h0000;
    logic [15:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            `HRM_ADDR_SEQ_CFG: rd_mux = seq_cfg_r;
            `HRM_ADDR_THERMAL: rd_mux = thermal_r;
            `HRM_ADDR_FIRST_A: rd_mux = first_a_r;
            `HRM_ADDR_FIRST_B: rd_mux = first_b_r;
            `HRM_ADDR_SECOND_A: rd_mux = second_a_r;
            `HRM_ADDR_SECOND_B: rd_mux = second_b_r;
            `HRM_ADDR_STRENGTH: rd_mux = strength_r;
            `HRM_ADDR_DIRECTION: rd_mux = direction_r;
            `HRM_ADDR_LIN_EXTRA: rd_mux = slot_lin;
            `HRM_ADDR_EXTRA_Z: rd_mux = slot_extra;
            default: rd_mux = 16'h0000;
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
        end
    end

    // helper: cycles since the rate counter last reloaded
    logic [16:0] gap_r;
    logic signed [16:0] chk_first_r, chk_second_r; // cordic inputs of the run
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            gap_r <= 17'h00000;
            chk_first_r <= 17'h00000;
            chk_second_r <= 17'h00000;
        end else begin
            gap_r <= (rate_hit || cfg_wr) ? 17'h00000 : gap_r + 17'h00001;
            if (cordic_start) begin
                chk_first_r <= cin_first;
                chk_second_r <= cin_second;
            end
        end
    end
    property p_seq_reset;
        @(posedge ref_clk_in) $rose(reset_n_in) |-> seq_cfg_r == 16'h0002;
    endproperty
    a_seq_reset: assert property (p_seq_reset) else $error("sequencer reset value wrong");
    property p_cfg_write;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            cfg_wr |=> seq_cfg_r == $past(reg_wdata_in);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
    property p_rate;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            rate_hit && !cfg_wr && $past(reset_n_in) && !$past(cfg_wr) && gap_r != 17'h00000
            |-> gap_r == reload;
    endproperty
    a_rate: assert property (p_rate) else $error("measurement period wrong");
    property p_side_map;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            sample_valid_in && map_sel == 2'h3 |=>
            first_a_r == $past(pixel_a_y_field_in) && second_b_r == $past(pixel_b_x_field_in);
    endproperty
    a_side_map: assert property (p_side_map) else $error("select 11 mapping wrong");
    property p_single_map;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            sample_valid_in && map_sel == 2'h0 |=>
            first_b_r == $past(pixel_a_z_field_in) && second_b_r == $past(pixel_a_y_field_in);
    endproperty
    a_single_map: assert property (p_single_map) else $error("single probe mapping wrong");
    property p_dual_extra;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            sample_valid_in && extra_on ##1 extra_on && !sample_valid_in |->
            slot_lin == $past(pixel_b_z_field_in) && slot_extra == $past(pixel_a_z_field_in);
    endproperty
    a_dual_extra: assert property (p_dual_extra) else $error("extra z slots wrong");
    // judged at the read port, so the read decode is covered too
    property p_no_extra;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            reg_rd_in && !(extra_fld == 2'h3 && map_sel == 2'h1) &&
            (reg_addr_in == `HRM_ADDR_EXTRA_Z || reg_addr_in == `HRM_ADDR_LIN_EXTRA) |=>
            reg_rdata_out == (($past(reg_addr_in) == `HRM_ADDR_EXTRA_Z) ? 16'h0000 : $past(lin_angle_r));
    endproperty
    a_no_extra: assert property (p_no_extra) else $error("extra slot without enable");
    // done is raised by the 16th step and seen one edge later
    property p_cordic_time;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            cordic_start |-> !cordic_done_r [*8] ##10 cordic_done_r;
    endproperty
    a_cordic_time: assert property (p_cordic_time) else $error("cordic run length wrong");
    property p_angle_quadrant;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            cordic_done_r && chk_first_r > 17'sh00010 && chk_second_r > 17'sh00010
            |=> $signed(direction_r) > 0 && $signed(direction_r) < 16'sh4000;
    endproperty
    a_angle_quadrant: assert property (p_angle_quadrant) else $error("angle quadrant wrong");
    property p_mask;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
            $stable(map_sel) && map_sel == 2'h1 |=> measure_mask_out == 6'h3F;
    endproperty
    a_mask: assert property (p_mask) else $error("dual probe mask wrong");

endmodule

`default_nettype wire

// File: shared/hrm_cfg.svh
/*
 * constants of the result mapper: register offsets, sequencer field
 * positions, reset value and measurement timing.
 * assumes a 50 MHz system clock; included by bare name.
 */
`ifndef HRM_CFG_SVH
`define HRM_CFG_SVH

// register offsets on the sensor register port
`define HRM_ADDR_SEQ_CFG 16'h000B
`define HRM_ADDR_THERMAL 16'h0110
`define HRM_ADDR_FIRST_A 16'h0111
`define HRM_ADDR_FIRST_B 16'h0112
`define HRM_ADDR_SECOND_A 16'h0113
`define HRM_ADDR_SECOND_B 16'h0114
`define HRM_ADDR_STRENGTH 16'h0120
`define HRM_ADDR_DIRECTION 16'h0121
`define HRM_ADDR_LIN_EXTRA 16'h0122
`define HRM_ADDR_EXTRA_Z 16'h0124

// sequencer field positions
`define HRM_RDY_HIZ_BIT 1
`define HRM_GRADIENT_BIT 4
`define HRM_MAP_SEL_LSB 6
`define HRM_EXTRA_LSB 8
`define HRM_SEQ_RESET 16'h0002

// result map select and extra-component codes
`define HRM_MAP_SINGLE 2'h0
`define HRM_MAP_DUAL 2'h1
`define HRM_MAP_ONTOP 2'h2
`define HRM_MAP_SIDE 2'h3
`define HRM_EXTRA_ON 2'h3

// measurement timing
`define HRM_CLK_MHZ 50
`define HRM_FAST_PERIOD_US 1000
`define HRM_SLOW_PERIOD_US 2000
`define HRM_CORDIC_STEPS 16

`endif

// File: shared/hrm_pkg.sv
/*
 * types of the result mapper.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package hrm_pkg;
    typedef logic signed [15:0] hrm_field_t; // one field or angle word
    typedef enum {HRM_IDLE, HRM_ITER} hrm_cordic_e; // cordic sequencer
endpackage

`default_nettype wire

// File: verification/hrm_front_end_model.sv
/*
 * behavioural model of the sensor front end: answers each measurement
 * trigger with one sample of temperature and six field words.
 * assumes the result mapper drives trigger and mask on clk_in.
 */
`default_nettype none

module hrm_front_end_model (
    input wire logic clk_in,
    input wire logic trigger_in,
    input wire logic [5:0] mask_in,
    input wire logic [95:0] fields_in,
    input wire logic [15:0] temp_in,
    output logic valid_out,
    output logic [95:0] fields_out,
    output logic [15:0] temp_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic go_r; // trigger seen, sample due next cycle

    initial begin
        valid_out = 1'b0;
        go_r = 1'b0;
        fields_out = '0;
        temp_out = '0;
    end

    // drives on the falling edge; words toggle between samples so that
    // a stale value is never mistaken for a fresh result
    always @(negedge clk_in) begin
        valid_out <= go_r;
        go_r <= trigger_in;
        temp_out <= go_r ? temp_in : ~temp_out;
        for (int i = 0; i < 6; i++) begin
            // unmasked components are not converted and carry junk
            fields_out[i*16 +: 16] <= (go_r && mask_in[i]) ? fields_in[i*16 +: 16] : ~fields_out[i*16 +: 16];
        end
    end
endmodule

`default_nettype wire

// File: verification/tb_hrm_result_mapper.sv
/*
 * self-checking bench of the result mapper: register port, rate,
 * slot mapping per mode, cordic and linearized outputs.
 * assumes the front end model file and the design are compiled first.
 */
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module tb_hrm_result_mapper;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FAST = 20; // shortened periods keep the run brief
    localparam int SLOW = 40;
    // field index per raw slot: 0 a_x, 1 a_y, 2 a_z, 3 b_x, 4 b_y, 5 b_z
    localparam int MAP [4][4] = '{'{2, 2, 0, 1}, '{4, 1, 3, 0}, '{2, 5, 0, 3}, '{1, 4, 0, 3}};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = '0;
    logic [15:0] wdata = '0;
    logic lin_wr = 1'b0;
    logic [4:0] lin_idx = '0;
    logic [16:0] lin_data = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic trig;
    logic hiz;
    logic [5:0] mask;
    logic valid;
    logic [95:0] fout;
    logic [15:0] tout;
    logic [15:0] fv [6] = '{16'h0300, 16'h0011, 16'h0400, 16'h0700, 16'h0022, 16'h0A00};
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    hrm_front_end_model fe_u (.clk_in(clk), .trigger_in(trig), .mask_in(mask),
        .fields_in({fv[5], fv[4], fv[3], fv[2], fv[1], fv[0]}), .temp_in(16'h0155),
        .valid_out(valid), .fields_out(fout), .temp_out(tout));

    // table load port idle until the table scenario: identity table before it
    hrm_result_mapper #(.FAST_PERIOD_CYC(FAST), .SLOW_PERIOD_CYC(SLOW)) dut_u (
        .ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .sample_valid_in(valid), .temperature_in(tout),
        .pixel_a_x_field_in(fout[15:0]), .pixel_a_y_field_in(fout[31:16]),
        .pixel_a_z_field_in(fout[47:32]), .pixel_b_x_field_in(fout[63:48]),
        .pixel_b_y_field_in(fout[79:64]), .pixel_b_z_field_in(fout[95:80]),
        .lin_wr_in(lin_wr), .lin_idx_in(lin_idx), .lin_data_in(lin_data),
        .meas_trigger_out(trig), .measure_mask_out(mask), .ready_pin_hiz_out(hiz));

    initial begin
        forever #10 clk = ~clk;
    end

    // hang guard: whole run needs roughly 750 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(negedge clk);
        wr <= 1'b0;
    endtask

    // answer is polled a few cycles only; a missing pulse is a mismatch
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        int k;
        @(negedge clk);
        addr <= a;
        rd <= 1'b1;
        @(negedge clk);
        rd <= 1'b0;
        k = 0;
        while (rvalid !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        `CHK("rvalid", 1'b1, rvalid)
        d = rdata;
    endtask

    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (trig !== 1'b1 && n < 200);
    endtask

    // cordic results are approximate, so a tolerance is allowed
    function automatic logic near(input logic [15:0] got, input logic sgn, input real e, input real tol);
        real g;
        if ($isunknown(got)) return 1'bx;
        if (sgn) g = $signed(got);
        else g = got;
        return (g - e <= tol) && (e - g <= tol);
    endfunction

    task automatic check_mode(input logic [15:0] cfg);
        int n;
        logic [15:0] d;
        logic [1:0] s;
        logic ext;
        real f;
        real g;
        real e_ang;
        s = cfg[7:6];
        ext = (cfg[9:8] == 2'h3) && (s == 2'h1);
        wr_reg(16'h000B, cfg);
        rd_reg(16'h000B, d);
        `CHK("seq_cfg", cfg, d)
        wait_trig(n);
        wait_trig(n);
        `CHK("period", (s == 2'h1) ? SLOW : FAST, n)
        `CHK("mask", (s == 2'h0) ? 6'h07 : 6'h3F, mask)
        `CHK("hiz", cfg[1], hiz)
        repeat (22) @(negedge clk);
        rd_reg(16'h0110, d);
        `CHK("temperature", 16'h0155, d)
        for (int i = 0; i < 4; i++) begin
            rd_reg(16'h0111 + 16'(i), d);
            `CHK("raw_slot", fv[MAP[s][i]], d)
        end
        // gradient feeds slot differences, absolute the first and third slot
        if (cfg[4]) begin
            f = $signed(fv[MAP[s][1]]) - $signed(fv[MAP[s][0]]);
            g = $signed(fv[MAP[s][3]]) - $signed(fv[MAP[s][2]]);
        end else begin
            f = $signed(fv[MAP[s][0]]);
            g = $signed(fv[MAP[s][2]]);
        end
        e_ang = $atan2(f, g) * 32768.0 / 3.141592653589793;
        rd_reg(16'h0120, d);
        `CHK("magnitude", 1'b1, near(d, 1'b0, 0.8234 * $sqrt(f * f + g * g), 8.0))
        rd_reg(16'h0121, d);
        `CHK("angle", 1'b1, near(d, 1'b1, e_ang, 24.0))
        rd_reg(16'h0122, d);
        if (ext) begin
            `CHK("extra_b_z", fv[5], d)
        end else begin
            `CHK("lin_angle", 1'b1, near(d, 1'b1, e_ang, 40.0))
        end
        rd_reg(16'h0124, d);
        `CHK("extra_z", ext ? fv[2] : 16'h0000, d)
    endtask

    // reset state, read-only and unmapped places
    task automatic scen_reset();
        logic [15:0] d;
        `CHK("hiz_rst", 1'b1, hiz)
        rd_reg(16'h000B, d);
        `CHK("seq_rst", 16'h0002, d)
        wr_reg(16'h0120, 16'h1234);
        rd_reg(16'h0120, d);
        `CHK("ro_write", 16'h0000, d)
        rd_reg(16'h0123, d);
        `CHK("unmapped", 16'h0000, d)
    endtask

    task automatic scen_single();
        check_mode(16'h0000);
        check_mode(16'h0302);
    endtask

    task automatic scen_dual();
        check_mode(16'h0342);
        check_mode(16'h0042);
    endtask

    task automatic scen_ontop();
        check_mode(16'h0082);
        check_mode(16'h0092);
    endtask

    task automatic scen_side();
        check_mode(16'h00C2);
    endtask

    // half-scale user table: the linearized angle must follow the table
    task automatic scen_lin_table();
        int n;
        logic [15:0] d;
        real e;
        wr_reg(16'h000B, 16'h00C2);
        for (int i = 0; i < 17; i++) begin
            @(negedge clk);
            lin_wr <= 1'b1;
            lin_idx <= 5'(i);
            lin_data <= 17'(i * 2048 - 16384);
        end
        @(negedge clk);
        lin_wr <= 1'b0;
        wait_trig(n);
        repeat (22) @(negedge clk);
        e = $atan2($signed(fv[1]), $signed(fv[0])) * 16384.0 / 3.141592653589793;
        rd_reg(16'h0122, d);
        `CHK("lin_table", 1'b1, near(d, 1'b1, e, 24.0))
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        scen_reset();
        scen_single();
        scen_dual();
        scen_ontop();
        scen_side();
        scen_lin_table();
        tally_and_finish();
    end
endmodule

`default_nettype wire
